// File: hw/pulse_axis_immediate_stop.sv
// Immediate stop command for a pulse output axis
`timescale 1ns/1ps
`include "axis_stop_params.svh"
module pulse_axis_immediate_stop
    import axis_stop_pkg::*;
#(
    // Number of pulse axes served by this block
    parameter int AXIS_NUM  = `AXIS_NUM_DEFAULT,
    // Clock cycles in one scan period
    parameter int SCAN_DIV  = `SCAN_DIV_DEFAULT,
    // Scans allowed for the axis to settle
    parameter int STOP_WAIT = `STOP_WAIT_DEFAULT,
    // Width of the axis index
    parameter int AW        = $clog2(AXIS_NUM)
) (
    // Clock and asynchronous reset
    input  wire logic                mclk,
    input  wire logic                nrst,
    // Command from the controlling program
    input  wire logic                trigger_in,
    input  wire logic [AW-1:0]       pulse_axis_handle,
    // Per-axis state from the pulse generator
    input  wire logic [AXIS_NUM-1:0] axis_enabled,
    input  wire logic [AXIS_NUM-1:0] axis_moving,
    input  wire logic [AXIS_NUM-1:0] axis_fault,
    // Halt latch toward the generator, flags toward the program
    output logic [AXIS_NUM-1:0]      pulse_halt,
    output status_t                  status
);

    // Internal state and next values
    logic                rst_s1_q, rst_n_q;     // Reset release pair
    logic [15:0]         div_q;                 // Scan divider
    logic                scan_q;                // Scan enable pulse
    logic                trig_prev_q;           // Trigger at last scan
    state_t              state_q, state_d;      // Command state
    logic [AW-1:0]       axis_q;                // Latched axis
    logic [7:0]          wait_q;                // Stop wait counter
    logic [AXIS_NUM-1:0] halt_d;                // Next halt latch
    status_t             st_d;                  // Next status word

    // Release reset through two flops
    // Raw nrst only clears this pair; all other logic uses rst_n_q
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            // Hold the whole block in reset
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            // Release one clock after the first flop
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Last clock of a scan period
    wire div_wrap    = (div_q == 16'(SCAN_DIV - 1));

    // Scan period enable
    // One clock pulse per scan; every command decision waits for it
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            // Divider starts a fresh period
            div_q  <= 16'h0000;
            scan_q <= 1'b0;
        end else begin
            // Pulse follows the wrap by one clock
            scan_q <= div_wrap;
            div_q  <= div_wrap ? 16'h0000 : div_q + 16'h0001;
        end
    end

    // Trigger edges evaluated once per scan
    wire trig_rise   = scan_q && trigger_in && !trig_prev_q;
    wire trig_fall   = scan_q && !trigger_in && trig_prev_q;

    // Validity checks on new command
    // Enable bit is only meaningful after the range check
    wire axis_ok     = (32'(pulse_axis_handle) < AXIS_NUM);
    wire sel_enabled = axis_ok && axis_enabled[pulse_axis_handle];
    // Status of the axis latched at the start
    wire cur_fault   = axis_fault[axis_q];
    wire cur_moving  = axis_moving[axis_q];
    // Settle time used up
    wire wait_out    = (wait_q >= 8'(STOP_WAIT));
    // Done seen at a scan with the trigger already low
    wire done_expire = scan_q && status.completion_flag && !trigger_in;

    // Next state and status
    // Clears come first so that a set later in the same scan wins
    always_comb begin
        // Hold everything unless a branch below changes it
        state_d = state_q;
        st_d    = status;
        halt_d  = pulse_halt;
        if (done_expire) begin
            st_d.completion_flag = 1'b0;
        end
        // clear done on trigger low
        // A fall and a start never meet in one scan
        if (trig_fall) begin
            st_d.completion_flag = 1'b0;
            st_d.fault_flag = 1'b0;
            st_d.fault_code = no_fault_value;
        end
        // Command sequence per state
        case (state_q)
            st_idle: begin
                if (trig_rise) begin
                    // Old flags drop as a new command starts
                    st_d.completion_flag = 1'b0;
                    st_d.fault_flag      = 1'b0;
                    st_d.fault_code      = no_fault_value;
                    // Refused starts never raise busy
                    if (!axis_ok) begin
                        st_d.fault_flag = 1'b1;
                        st_d.fault_code = fault_bad_axis;
                        state_d = st_end;
                    end else if (!sel_enabled) begin
                        st_d.fault_flag = 1'b1;
                        st_d.fault_code = fault_axis_err;
                        state_d = st_end;
                    end else begin
                        // Accepted: halt the axis and go busy
                        // in progress from start
                        st_d.in_progress_flag = 1'b1;
                        halt_d[pulse_axis_handle] = 1'b1;
                        state_d = st_stop;
                    end
                end
            end

            st_stop: begin
                // Axis checked once per scan while the halt takes hold
                if (scan_q) begin
                    if (cur_fault) begin
                        st_d.fault_flag = 1'b1;
                        st_d.fault_code = fault_axis_err;
                        st_d.in_progress_flag = 1'b0;
                        state_d = st_end;
                    end else if (!cur_moving) begin
                        st_d.completion_flag  = 1'b1;
                        st_d.in_progress_flag = 1'b0;
                        state_d = st_end;
                    end else if (wait_out) begin
                        st_d.fault_flag = 1'b1;
                        st_d.fault_code = fault_timeout;
                        st_d.in_progress_flag = 1'b0;
                        state_d = st_end;
                    end
                end
            end

            st_end: begin
                // Back to idle once the trigger is low
                // A trigger held high keeps the flags standing
                if (scan_q && !trigger_in) begin
                    state_d = st_idle;
                end
            end
            // Unused encoding recovers to idle
            default: state_d = st_idle;
        endcase
    end

    // Command registers
    // Every output is a flop, cleared while reset is held
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            // Idle, flags low, no axis halted
            state_q     <= st_idle;
            status      <= '{1'b0, 1'b0, 1'b0, no_fault_value};
            pulse_halt  <= '0;
            trig_prev_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            status     <= st_d;
            // Halt bits are only set; reset alone releases them
            pulse_halt <= halt_d;
            // Trigger history moves only at a scan
            if (scan_q) begin
                trig_prev_q <= trigger_in;
            end
        end
    end

    // Axis latch and wait counter
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            // Latch and counter start clear
            axis_q      <= '0;
            wait_q      <= 8'h00;
        end else begin
            // Rises while busy or ending are not accepted
            // sample axis on every start seen in idle, refused ones included
            if (state_q == st_idle && trig_rise && !status.in_progress_flag) begin
                axis_q <= pulse_axis_handle;
            end
            // Counter runs only while a stop is pending
            if (state_q != st_stop) begin
                wait_q <= 8'h00;
            end else if (scan_q && !wait_out) begin
                // One count per scan, saturating at the limit
                wait_q <= wait_q + 8'h01;
            end
        end
    end
endmodule

// File: hw/axis_stop_params.svh
// Constants for the pulse axis immediate stop block
// Functional notes
// - Trigger rise starts stop, halts selected axis
// - Pulses cease at once, no deceleration ramp
// - Completion flag set when stop finishes
// - Completion clears on trigger low, else one scan
// - In-progress rises with trigger and command start
// - Fault flag on invalid conditions or inputs
// - Fault code recorded with fault, else no-fault
// - Trigger fall clears fault flag and code
`ifndef AXIS_STOP_PARAMS_SVH
`define AXIS_STOP_PARAMS_SVH
`define AXIS_NUM_DEFAULT 4
`define SCAN_DIV_DEFAULT 16
`define STOP_WAIT_DEFAULT 4
`endif

// File: hw/axis_stop_pkg.sv
// Types for the pulse axis immediate stop block
package axis_stop_pkg;
    // Enumerated fault codes
    typedef enum logic [3:0] {
        no_fault_value = 4'h0,
        fault_bad_axis = 4'h1,
        fault_axis_err = 4'h2,
        fault_timeout  = 4'h3
    } fault_code_enum_t;
    // Command state
    typedef enum logic [1:0] {st_idle, st_stop, st_end} state_t;
    // Status flags toward the program
    typedef struct packed {
        logic             completion_flag;
        logic             in_progress_flag;
        logic             fault_flag;
        fault_code_enum_t fault_code;
    } status_t;
endpackage

// File: bench/axis_gen_model.sv
// Behavioural pulse generator standing behind the stop block
`timescale 1ns/1ps
module axis_gen_model #(parameter int AXIS_NUM = 4) (
    input  wire logic                mclk,
    input  wire logic                nrst,
    input  wire logic                stall,
    input  wire logic [AXIS_NUM-1:0] pulse_halt,
    output logic [AXIS_NUM-1:0]      axis_moving
);
    // Halted axes stop one cycle later, unless stalled
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            axis_moving <= '1;
        end else if (!stall) begin
            axis_moving <= axis_moving & ~pulse_halt;
        end
    end
endmodule

// File: bench/axis_stop_monitor.sv
// Assertion checker for the stop block
`timescale 1ns/1ps
module axis_stop_monitor
    import axis_stop_pkg::*;
#(parameter int AXIS_NUM = 4) (
    input wire logic                mclk,
    input wire logic                nrst,
    input wire logic                trigger_in,
    input wire logic [AXIS_NUM-1:0] pulse_halt,
    input wire status_t             status
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_start_on_trig: assert property ($rose(status.in_progress_flag) |-> $past(trigger_in))
        else $error("busy without trigger");
    a_halt_on_start: assert property ($rose(status.in_progress_flag) |-> pulse_halt != 0)
        else $error("no halt at start");
    a_halt_kept: assert property ((pulse_halt & $past(pulse_halt)) == $past(pulse_halt))
        else $error("halt released");
    a_busy_done: assert property (!(status.in_progress_flag && status.completion_flag))
        else $error("busy with done");
    a_busy_fault: assert property (!(status.in_progress_flag && status.fault_flag))
        else $error("busy with fault");
    a_code_match: assert property (status.fault_flag == (status.fault_code != no_fault_value))
        else $error("code mismatch");
    a_fault_clear: assert property ($fell(status.fault_flag) |-> !$past(trigger_in))
        else $error("fault dropped early");
    a_done_clear: assert property ($fell(status.completion_flag) |-> !$past(trigger_in))
        else $error("done dropped early");
endmodule
bind pulse_axis_immediate_stop axis_stop_monitor #(.AXIS_NUM(AXIS_NUM)) mon (.mclk(mclk),
    .nrst(nrst), .trigger_in(trigger_in), .pulse_halt(pulse_halt), .status(status));

// File: bench/pulse_axis_immediate_stop_test.sv
// Self-checking bench for the stop block
`timescale 1ns/1ps
module pulse_axis_immediate_stop_test;
    import axis_stop_pkg::*;
    localparam int SD = 4;
    logic       mclk = 0, nrst = 0, trig = 0, stall = 0;
    logic [1:0] ax   = '0;
    logic [3:0] en   = 4'hF, flt = 4'h0, mov, halt;
    status_t    st;
    int         bad_count = 0, total_checks = 0, cyc = 0;
    pulse_axis_immediate_stop #(.AXIS_NUM(4), .SCAN_DIV(SD), .STOP_WAIT(4)) uut (.mclk(mclk),
        .nrst(nrst), .trigger_in(trig), .pulse_axis_handle(ax), .axis_enabled(en),
        .axis_moving(mov), .axis_fault(flt), .pulse_halt(halt), .status(st));
    axis_gen_model #(.AXIS_NUM(4)) gen (.mclk(mclk), .nrst(nrst), .stall(stall),
        .pulse_halt(halt), .axis_moving(mov));
    initial forever #4 mclk = ~mclk;
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Raise trigger, wait for done or fault
    task automatic fire(input logic [1:0] a);
        int n;
        n = 0;
        @(posedge mclk);
        trig <= 1'b1;
        ax   <= a;
        while (!(st.completion_flag | st.fault_flag) && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        // Limit reached counts as a mismatch
        if (n >= 100) begin
            bad_count++;
        end
    endtask
    // Drop trigger, flags must clear
    task automatic drop();
        @(posedge mclk);
        trig <= 1'b0;
        repeat (3 * SD) @(posedge mclk);
        #1;
        chk("done", st.completion_flag, 1'b0);
        chk("fault", st.fault_flag, 1'b0);
        chk("code", st.fault_code, no_fault_value);
    endtask
    task automatic sc_normal();
        fire(2'd1);
        chk("done", st.completion_flag, 1'b1);
        chk("halt", halt, 4'h2);
        @(posedge mclk);
        ax <= 2'd3;
        repeat (2 * SD) @(posedge mclk);
        #1;
        chk("halt", halt, 4'h2);
        chk("done", st.completion_flag, 1'b1);
        drop();
    endtask
    // Short trigger: done must stand one scan, then clear
    task automatic sc_short();
        int n;
        n = 0;
        @(posedge mclk);
        trig <= 1'b1;
        ax   <= 2'd1;
        while (!st.in_progress_flag && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);
        trig <= 1'b0;
        n = 0;
        while (!st.completion_flag && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 100) begin
            bad_count++;
        end
        chk("busy", st.in_progress_flag, 1'b0);
        repeat (SD - 1) @(posedge mclk);
        #1;
        chk("done", st.completion_flag, 1'b1);
        @(posedge mclk);
        #1;
        chk("done", st.completion_flag, 1'b0);
    endtask
    task automatic sc_refused();
        @(posedge mclk);
        en  <= 4'hB;
        flt <= 4'h8;
        fire(2'd2);
        chk("code", st.fault_code, fault_axis_err);
        drop();
        fire(2'd3);
        chk("code", st.fault_code, fault_axis_err);
        drop();
    endtask
    task automatic sc_timeout();
        @(posedge mclk);
        stall <= 1'b1;
        fire(2'd0);
        chk("code", st.fault_code, fault_timeout);
        chk("halt", halt[0], 1'b1);
        drop();
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3 * SD) @(posedge mclk);
        sc_normal();
        sc_short();
        sc_refused();
        sc_timeout();
        stop_test();
    end
endmodule
